// file: logic/supply_voltage_supervisor_ctrl.sv
// Control logic of the low-supply-voltage supervisor: reset, interrupt, registers.
// Assumes analogue comparators outside, option byte valid at reset release.
//
// Operation
// - Combined mode 1,0: high threshold releases reset and raises the interrupt.
// - Combined mode: supply below low threshold asserts the internal reset.
// - Combined mode: fall below high raises interrupt; at or above high releases.
// - Reset-only mode 1,1: reset while below threshold, released at or above.
// - Interrupt-only mode 0,1: one threshold releases hold, then raises interrupts.
// - Interrupt-only mode: internal reset held until supply first reaches threshold.
// - Interrupt-only mode: after release, interrupt on every crossing either way.
// - Control bit 0 reads 1 while supply below threshold, else 0; always 0 with detection off.
// - Supervisor reset sets bit 0 of the reset-source flags.
// - Other resets clear control to 00; supervisor reset keeps write-enable.
// - Write-enable 0 blocks level writes, unmasked; 1 permits writes and, in combined mode, masks.
// - Mask status and detection flag bits are read-only.
// - Combined mode: mask set while write-enable or threshold settling.
// - Supervisor reset keeps level register; others load 00, 81 or 01 by mode.
// - Combined mode: level bits switch by hardware on release from supervisor reset or on interrupt.
// - After combined-mode interrupt, level select and mode bits both set.
// - Level bit 7 is mode (1 reset), bit 0 selects low threshold.
`timescale 1ns/10ps
`default_nettype none

module supply_voltage_supervisor_ctrl (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CMP_BELOW_HI,
  input  wire logic        CMP_BELOW_LO,
  input  wire logic [7:0]  OPT_BYTE,
  input  wire logic [19:0] REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        RFLAG_CLR,
  output logic      [7:0]  REG_RDATA,
  output logic             SUP_RESET,
  output logic             LOW_SUPPLY_IRQ,
  output logic             SUPERVISOR_RESET_FLAG,
  output logic      [4:0]  THRESH_CODE,
  output logic             THRESH_SEL_LOW
);

  // ==========================================================================
  // Comparator synchronisation
  // ==========================================================================
  logic [1:0] below_s;   // [0] high or single threshold, [1] low threshold

  level_sync3 #(
    .WIDTH(2)
  ) u_sync (
    .clk       (CLK),
    .nrst      (NRST),
    .async_in  ({CMP_BELOW_LO, CMP_BELOW_HI}),
    .stable_out(below_s)
  );

  // ==========================================================================
  // State
  // ==========================================================================
  supervisor_pkg::sup_state_type state_r, state_nxt;
  supervisor_pkg::opt_type       opt_r, opt_nxt;
  logic [7:0]                    level_r, level_nxt;
  logic                          wen_r, wen_nxt;
  logic [supervisor_pkg::SETTLE_W-1:0] settle_r, settle_nxt;
  logic                          prev_below_r, prev_below_nxt;
  logic                          rst_r, rst_nxt;
  logic                          irq_r, irq_nxt;
  logic                          rflag_r, rflag_nxt;
  logic [7:0]                    rdata_r, rdata_nxt;

  logic combined;
  logic mask;
  logic sel_below;
  logic flag;

  // Live decode of mode, mask and selected comparator
  always_comb begin
    combined  = (opt_r.mode == supervisor_pkg::MODE_CMB);
    mask      = combined && (wen_r || (settle_r != supervisor_pkg::SETTLE_IDLE));
    sel_below = (combined && level_r[supervisor_pkg::LVL_SEL_BIT]) ? below_s[1] : below_s[0];
    flag      = ((state_r == supervisor_pkg::ST_RUN) || (state_r == supervisor_pkg::ST_HOLD)) && sel_below;
  end

  // ==========================================================================
  // Sequencer and register writes
  // ==========================================================================
  // Next-state logic; in combined mode hardware events never meet a level write because
  // a permitted write implies the mask is on
  always_comb begin
    state_nxt      = state_r;
    opt_nxt        = opt_r;
    level_nxt      = level_r;
    wen_nxt        = wen_r;
    settle_nxt     = (settle_r != supervisor_pkg::SETTLE_IDLE) ? settle_r - 1'b1 : settle_r;
    prev_below_nxt = prev_below_r;
    rst_nxt        = rst_r;
    irq_nxt        = 1'b0;
    rflag_nxt      = rflag_r;
    if (RFLAG_CLR) begin
      rflag_nxt = 1'b0;
    end
    case (state_r)
      supervisor_pkg::ST_BOOT: begin
        opt_nxt = supervisor_pkg::opt_type'(OPT_BYTE);
        case (OPT_BYTE[1:0])
          supervisor_pkg::MODE_RST: level_nxt = supervisor_pkg::LEVEL_RST_RST;
          supervisor_pkg::MODE_IRQ: level_nxt = supervisor_pkg::LEVEL_RST_IRQ;
          default:                  level_nxt = supervisor_pkg::LEVEL_RST_CMB;
        endcase
        if (OPT_BYTE[1:0] == supervisor_pkg::MODE_OFF) begin
          state_nxt = supervisor_pkg::ST_OFF;
        end else begin
          state_nxt = supervisor_pkg::ST_HOLD;
          rst_nxt   = 1'b1;
        end
      end
      supervisor_pkg::ST_HOLD: begin
        // Every mode releases on the high or single threshold
        if (!below_s[0]) begin
          state_nxt      = supervisor_pkg::ST_RUN;
          rst_nxt        = 1'b0;
          prev_below_nxt = 1'b0;
          if (combined) begin
            level_nxt = supervisor_pkg::LEVEL_RST_CMB;
          end
        end
      end
      supervisor_pkg::ST_RUN: begin
        prev_below_nxt = sel_below;
        case (opt_r.mode)
          supervisor_pkg::MODE_RST: begin
            if (below_s[0]) begin
              state_nxt = supervisor_pkg::ST_HOLD;
              rst_nxt   = 1'b1;
              rflag_nxt = 1'b1;
            end
          end
          supervisor_pkg::MODE_IRQ: begin
            if (sel_below != prev_below_r) begin
              irq_nxt = 1'b1;
            end
          end
          supervisor_pkg::MODE_CMB: begin
            if (!mask && level_r[supervisor_pkg::LVL_MODE_BIT] && sel_below) begin
              state_nxt = supervisor_pkg::ST_HOLD;
              rst_nxt   = 1'b1;
              rflag_nxt = 1'b1;
            end else if (!mask && !level_r[supervisor_pkg::LVL_MODE_BIT] && sel_below && !prev_below_r) begin
              irq_nxt    = 1'b1;
              level_nxt  = supervisor_pkg::LEVEL_IRQ_SET;
              settle_nxt = supervisor_pkg::SETTLE_LOAD;
            end
          end
          default: begin
            state_nxt = supervisor_pkg::ST_OFF;
          end
        endcase
        // Writes taken only while the supervisor is not holding reset
        if (REG_WR && (state_nxt == supervisor_pkg::ST_RUN)) begin
          if (REG_ADDR == supervisor_pkg::CTRL_ADDR) begin
            wen_nxt = REG_WDATA[supervisor_pkg::WEN_BIT];
          end else if ((REG_ADDR == supervisor_pkg::LEVEL_ADDR) && wen_r) begin
            level_nxt = REG_WDATA & supervisor_pkg::LEVEL_WR_MASK;
            if (REG_WDATA[supervisor_pkg::LVL_SEL_BIT] != level_r[supervisor_pkg::LVL_SEL_BIT]) begin
              settle_nxt = supervisor_pkg::SETTLE_LOAD;
            end
          end
        end
      end
      default: begin
        // Detection off: no reset, no interrupt, flag reads zero
        if (REG_WR && (REG_ADDR == supervisor_pkg::CTRL_ADDR)) begin
          wen_nxt = REG_WDATA[supervisor_pkg::WEN_BIT];
        end
      end
    endcase
    if (rflag_nxt == 1'b0 && rflag_r == 1'b0 && rst_nxt && !rst_r) begin
      rflag_nxt = 1'b1;  // Set wins over a same-cycle clear
    end
    if (state_r == supervisor_pkg::ST_BOOT) begin
      rflag_nxt = rflag_r && !RFLAG_CLR;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Registered read; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (REG_ADDR == supervisor_pkg::CTRL_ADDR) begin
      rdata_nxt[supervisor_pkg::WEN_BIT]  = wen_r;
      rdata_nxt[supervisor_pkg::MASK_BIT] = mask;
      rdata_nxt[supervisor_pkg::FLAG_BIT] = flag;
    end else if (REG_ADDR == supervisor_pkg::LEVEL_ADDR) begin
      rdata_nxt = level_r;
    end
  end

  // Registers; async reset is every non-supervisor reset source
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r      <= supervisor_pkg::ST_BOOT;
      opt_r        <= supervisor_pkg::opt_type'(supervisor_pkg::OPT_RST);
      level_r      <= supervisor_pkg::LEVEL_RST_CMB;
      wen_r        <= supervisor_pkg::CTRL_RST[supervisor_pkg::WEN_BIT];
      settle_r     <= supervisor_pkg::SETTLE_IDLE;
      prev_below_r <= 1'b0;
      rst_r        <= 1'b0;
      irq_r        <= 1'b0;
      rflag_r      <= 1'b0;
      rdata_r      <= 8'h00;
    end else begin
      state_r      <= state_nxt;
      opt_r        <= opt_nxt;
      level_r      <= level_nxt;
      wen_r        <= wen_nxt;
      settle_r     <= settle_nxt;
      prev_below_r <= prev_below_nxt;
      rst_r        <= rst_nxt;
      irq_r        <= irq_nxt;
      rflag_r      <= rflag_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    REG_RDATA             = rdata_r;
    SUP_RESET             = rst_r;
    LOW_SUPPLY_IRQ        = irq_r;
    SUPERVISOR_RESET_FLAG = rflag_r;
    THRESH_CODE           = {opt_r.vpoc, opt_r.level};
    THRESH_SEL_LOW        = level_r[supervisor_pkg::LVL_SEL_BIT];
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_hold_release;
    (state_r == supervisor_pkg::ST_HOLD) && !below_s[0] |=> !SUP_RESET ##1 !SUP_RESET || below_s[0];
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("reset not released at threshold");

  property p_rst_mode;
    (opt_r.mode == supervisor_pkg::MODE_RST) && (state_r == supervisor_pkg::ST_RUN) && below_s[0]
      |=> SUP_RESET && SUPERVISOR_RESET_FLAG;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("reset mode missed low supply");

  property p_cmb_reset;
    combined && (state_r == supervisor_pkg::ST_RUN) && !mask && level_r[7] && sel_below
      |=> SUP_RESET && SUPERVISOR_RESET_FLAG && $stable(wen_r);
  endproperty
  a_cmb_reset: assert property (p_cmb_reset) else $error("combined mode reset wrong");

  property p_cmb_irq;
    combined && (state_r == supervisor_pkg::ST_RUN) && !mask && !level_r[7] && sel_below && !prev_below_r
      |=> LOW_SUPPLY_IRQ && (level_r == 8'h81);
  endproperty
  a_cmb_irq: assert property (p_cmb_irq) else $error("combined interrupt or level switch missing");

  property p_irq_toggle;
    (opt_r.mode == supervisor_pkg::MODE_IRQ) && (state_r == supervisor_pkg::ST_RUN) && (sel_below != prev_below_r)
      |=> LOW_SUPPLY_IRQ ##1 !LOW_SUPPLY_IRQ || $changed(prev_below_r);
  endproperty
  a_irq_toggle: assert property (p_irq_toggle) else $error("crossing did not raise interrupt");

  property p_no_irq_in_hold;
    (state_r == supervisor_pkg::ST_HOLD) |=> !LOW_SUPPLY_IRQ;
  endproperty
  a_no_irq_in_hold: assert property (p_no_irq_in_hold) else $error("interrupt while reset held");

  property p_settle_mask;
    combined && LOW_SUPPLY_IRQ |-> mask [*8];
  endproperty
  a_settle_mask: assert property (p_settle_mask) else $error("mask dropped during settling");

  property p_level_blocked;
    REG_WR && (REG_ADDR == supervisor_pkg::LEVEL_ADDR) && !wen_r
      && (state_r == supervisor_pkg::ST_RUN) |=> $stable(level_r) || LOW_SUPPLY_IRQ;
  endproperty
  a_level_blocked: assert property (p_level_blocked) else $error("level written while locked");

  property p_flag_read;
    (REG_ADDR == supervisor_pkg::CTRL_ADDR) |=> (REG_RDATA[0] == $past(flag)) && (REG_RDATA[1] == $past(mask));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("status bits read wrong");

  property p_opt_held;
    (state_r != supervisor_pkg::ST_BOOT) |=> $stable(opt_r);
  endproperty
  a_opt_held: assert property (p_opt_held) else $error("option byte changed after release");

endmodule : supply_voltage_supervisor_ctrl

`default_nettype wire

// file: logic/supervisor_pkg.sv
// Shared constants and types for the supply-voltage supervisor control logic.
// Assumes a single 200 MHz system clock and an active-low asynchronous reset.
package supervisor_pkg;

  // ==========================================================================
  // Register addresses and field positions
  // ==========================================================================
  localparam logic [19:0] CTRL_ADDR     = 20'hfffa9;
  localparam logic [19:0] LEVEL_ADDR    = 20'hfffaa;
  localparam int          WEN_BIT       = 7;
  localparam int          MASK_BIT      = 1;
  localparam int          FLAG_BIT      = 0;
  localparam int          LVL_MODE_BIT  = 7;
  localparam int          LVL_SEL_BIT   = 0;
  localparam logic [7:0]  LEVEL_WR_MASK = 8'h81;

  // ==========================================================================
  // Values after reset and after a combined-mode interrupt
  // ==========================================================================
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  LEVEL_RST_CMB = 8'h00;
  localparam logic [7:0]  LEVEL_RST_RST = 8'h81;
  localparam logic [7:0]  LEVEL_RST_IRQ = 8'h01;
  localparam logic [7:0]  LEVEL_IRQ_SET = 8'h81;
  localparam logic [7:0]  OPT_RST       = 8'h00;

  // ==========================================================================
  // Mode encodings of the option byte
  // ==========================================================================
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_IRQ      = 2'h1;
  localparam logic [1:0]  MODE_CMB      = 2'h2;
  localparam logic [1:0]  MODE_RST      = 2'h3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          SETTLE_TIME_NS = 1000;
  localparam int          SETTLE_CYC     = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          SETTLE_W       = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC);
  localparam logic [SETTLE_W-1:0] SETTLE_IDLE = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [2:0] vpoc;
    logic       fixed_one;
    logic [1:0] level;
    logic [1:0] mode;
  } opt_type;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_OFF,
    ST_HOLD,
    ST_RUN
  } sup_state_type;

endpackage : supervisor_pkg

// file: logic/level_sync3.sv
// Three-stage synchroniser for asynchronous comparator levels.
// Assumes inputs settle for several clocks; output moves when stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none

module level_sync3 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Stage 1 feeds only stage 2, so metastability never reaches a decision
  // Reset to the below side: a hold cannot end before the real level arrives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r     <= '1;
      s2_r       <= '1;
      s3_r       <= '1;
      stable_out <= '1;
    end else begin
      meta_r <= async_in;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          stable_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : level_sync3

`default_nettype wire

// file: verif/supply_model.sv
// Behavioural model of the analogue supply comparators beside the supervisor.
// Assumes the bench sets the supply level in millivolts; outputs are asynchronous.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Comparator pair
// ==========================================================================
module supply_model #(
  parameter logic [15:0] HI_MV = 16'h0bb8,
  parameter logic [15:0] LO_MV = 16'h0af0
) (
  input  wire logic [15:0] supply_mv,
  output logic             below_hi,
  output logic             below_lo
);
  // Strictly below trips; at the level counts as good
  // Small delay keeps the edges away from the clock, as a real comparator would
  assign #3 below_hi = (supply_mv < HI_MV);
  assign #3 below_lo = (supply_mv < LO_MV);
endmodule : supply_model

`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the supervisor control: modes, registers and events.
// Assumes the comparator model in supply_model.sv and the design package.
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ========================================================================
  // Signals
  // ========================================================================
  localparam logic [15:0] V_OK  = 16'h0ce4;
  localparam logic [15:0] V_MID = 16'h0b54;
  localparam logic [15:0] V_LOW = 16'h0a8c;
  localparam logic [15:0] V_AT  = 16'h0bb8;
  localparam int          LIMIT = 6000;
  logic        clk, nrst, below_hi, below_lo, reg_wr, rflag_clr;
  logic        sup_rst, irq, rflag, sel_low, rd_req, rd_req_q;
  logic [7:0]  opt, wdata, rdata;
  logic [19:0] addr;
  logic [4:0]  tcode;
  logic [15:0] supply;
  logic [31:0] rnd;
  logic [7:0]  exp_q[$];
  string       nm_q[$];
  integer      seed, n_fail, cmp_count;
  integer      cyc = 0;

  supply_model u_cmp (.supply_mv(supply), .below_hi(below_hi), .below_lo(below_lo));

  supply_voltage_supervisor_ctrl DUT (
    .CLK(clk), .NRST(nrst), .CMP_BELOW_HI(below_hi), .CMP_BELOW_LO(below_lo),
    .OPT_BYTE(opt), .REG_ADDR(addr), .REG_WR(reg_wr), .REG_WDATA(wdata),
    .RFLAG_CLR(rflag_clr), .REG_RDATA(rdata), .SUP_RESET(sup_rst),
    .LOW_SUPPLY_IRQ(irq), .SUPERVISOR_RESET_FLAG(rflag), .THRESH_CODE(tcode),
    .THRESH_SEL_LOW(sel_low)
  );

  // ========================================================================
  // Clock, timeout and read-data monitor
  // ========================================================================
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // A hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  // Read data lands one edge after the address; oldest note is compared
  always @(posedge clk) rd_req_q <= rd_req;
  always @(negedge clk) begin
    if (rd_req_q === 1'b1 && exp_q.size() > 0) begin
      check(nm_q.pop_front(), rdata, exp_q.pop_front());
    end
  end

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic sel(input int k);
    return (k == 0) ? sup_rst : irq;
  endfunction : sel

  task automatic wait_for(input int k, input logic v, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sel(k) !== v && n < 30);
    check(nm, {7'h0, sel(k)}, {7'h0, v});
  endtask : wait_for

  // Output must stay low over a window, checked every cycle
  task automatic quiet(input int k, input int n, input string nm);
    repeat (n) begin
      @(negedge clk);
      check(nm, {7'h0, sel(k)}, 8'h00);
    end
  endtask : quiet

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string nm);
    @(negedge clk);
    addr = a;
    rd_req = 1'b1;
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(negedge clk);
    rd_req = 1'b0;
  endtask : rd

  task automatic do_reset(input logic [7:0] o);
    @(negedge clk);
    nrst = 1'b0;
    opt = o;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
  endtask : do_reset

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    {nrst, reg_wr, rflag_clr, rd_req} = '0;
    {opt, wdata, addr, n_fail, cmp_count} = '0;
    supply = V_OK;
    seed = 67;
    rnd = $random(seed);
    // Combined mode, level code 01
    do_reset(8'h16);
    wait_for(0, 1'b0, "cmb release");
    check("thresh code", {3'h0, tcode}, 8'h01);
    opt = 8'hff;
    repeat (2) @(negedge clk);
    check("thresh held", {3'h0, tcode}, 8'h01);
    rd(supervisor_pkg::LEVEL_ADDR, supervisor_pkg::LEVEL_RST_CMB, "level cmb");
    rd(supervisor_pkg::CTRL_ADDR, supervisor_pkg::CTRL_RST, "ctrl rst");
    wr(supervisor_pkg::CTRL_ADDR, {1'b1, rnd[6:0]});
    rd(supervisor_pkg::CTRL_ADDR, 8'h82, "ctrl wen");
    wr(supervisor_pkg::LEVEL_ADDR, 8'hff);
    rd(supervisor_pkg::LEVEL_ADDR, 8'h81, "level wr");
    wr(supervisor_pkg::LEVEL_ADDR, 8'h00);
    supply = V_MID;
    quiet(1, 20, "masked irq");
    supply = V_OK;
    wr(supervisor_pkg::CTRL_ADDR, 8'h00);
    wr(supervisor_pkg::LEVEL_ADDR, 8'h81);
    rd(supervisor_pkg::LEVEL_ADDR, 8'h00, "level locked");
    repeat (210) @(negedge clk);
    rd(supervisor_pkg::CTRL_ADDR, 8'h00, "mask clear");
    supply = V_MID;
    wait_for(1, 1'b1, "cmb irq");
    check("sel low", {7'h0, sel_low}, 8'h01);
    rd(supervisor_pkg::LEVEL_ADDR, supervisor_pkg::LEVEL_IRQ_SET, "level irq");
    repeat (210) @(negedge clk);
    supply = V_LOW;
    wait_for(0, 1'b1, "cmb reset");
    check("rst flag", {7'h0, rflag}, 8'h01);
    rd(supervisor_pkg::LEVEL_ADDR, 8'h81, "level kept");
    supply = V_OK;
    wait_for(0, 1'b0, "cmb rel");
    rd(supervisor_pkg::LEVEL_ADDR, 8'h00, "level back");
    @(negedge clk);
    rflag_clr = 1'b1;
    @(negedge clk);
    rflag_clr = 1'b0;
    check("flag clr", {7'h0, rflag}, 8'h00);
    rd({4'h0, rnd[31:16]}, 8'h00, "unmapped");
    $display("combined mode done");
    // Reset-only mode, supply low through release
    supply = V_LOW;
    do_reset(8'h1f);
    repeat (10) @(negedge clk);
    check("rst hold", {7'h0, sup_rst}, 8'h01);
    supply = V_AT;
    wait_for(0, 1'b0, "rst at level");
    rd(supervisor_pkg::LEVEL_ADDR, supervisor_pkg::LEVEL_RST_RST, "level rst");
    rd(supervisor_pkg::CTRL_ADDR, 8'h00, "flag clear");
    supply = V_MID;
    wait_for(0, 1'b1, "rst fall");
    rd(supervisor_pkg::CTRL_ADDR, 8'h01, "flag below");
    supply = V_OK;
    wait_for(0, 1'b0, "rst rise");
    $display("reset mode done");
    // Interrupt-only mode
    supply = V_MID;
    do_reset(8'h1d);
    repeat (10) @(negedge clk);
    check("irq hold", {7'h0, sup_rst}, 8'h01);
    supply = V_OK;
    wait_for(0, 1'b0, "irq rel");
    quiet(1, 10, "no irq rel");
    rd(supervisor_pkg::LEVEL_ADDR, supervisor_pkg::LEVEL_RST_IRQ, "level irqm");
    supply = V_MID;
    wait_for(1, 1'b1, "irq fall");
    rd(supervisor_pkg::CTRL_ADDR, 8'h01, "flag irqm");
    supply = V_OK;
    wait_for(1, 1'b1, "irq rise");
    quiet(0, 10, "no reset");
    $display("interrupt mode done");
    // Detection off
    supply = V_MID;
    do_reset(8'h1c);
    quiet(0, 10, "off reset");
    rd(supervisor_pkg::CTRL_ADDR, 8'h00, "flag off");
    $display("off mode done");
    end_of_test();
  end
endmodule : tb

`default_nettype wire
